// ### dfc_pkg.sv
// constants for the frame-check, calibration and slew front end
`default_nettype none
package dfc_pkg;
  localparam int unsigned MCLK_HZ = 20_000_000;
  localparam int unsigned LINK_CLK_NS = 6;
  // frame layout
  localparam logic [4:0] GROUP_LAST_BIT = 5'h1f;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_NONE = 8'h00;
  // hidden checking mode pattern
  localparam logic [7:0] PAT_HI = 8'h57;
  localparam logic [1:0] PAT_MID = 2'h3;
  localparam logic [7:0] PAT_LO = 8'h2b;
  // command addresses
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_DATA = 8'h01;
  localparam logic [7:0] ADDR_READ = 8'h02;
  localparam logic [7:0] ADDR_CTRL = 8'h55;
  localparam logic [7:0] ADDR_RESET = 8'h56;
  localparam logic [7:0] ADDR_CFG = 8'h57;
  localparam logic [7:0] ADDR_GAIN = 8'h58;
  localparam logic [7:0] ADDR_ZERO = 8'h59;
  // field positions
  localparam int unsigned CTRL_SLEW_EN = 4;
  localparam int unsigned CTRL_STEP_LSB = 5;
  localparam int unsigned CTRL_RATE_LSB = 8;
  localparam int unsigned CFG_CHECK_EN = 0;
  localparam int unsigned RESET_BIT = 0;
  localparam int unsigned STAT_SLEW = 1;
  localparam int unsigned STAT_FAULT = 2;
  // reset values and calibration
  localparam logic [15:0] GAIN_RESET = 16'h0000;
  localparam logic [15:0] ZERO_RESET = 16'h0000;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [16:0] GAIN_BIAS = 17'h08000;
  localparam logic [15:0] CODE_MAX_16 = 16'hffff;
  localparam logic [15:0] CODE_MAX_12 = 16'h0fff;
  // ramp position keeps four fraction bits (sixteenths of an lsb)
  localparam logic [11:0] STEP16 [8] = '{12'h010, 12'h020, 12'h040,
    12'h080, 12'h100, 12'h200, 12'h400, 12'h800};
  localparam logic [11:0] STEP12 [8] = '{12'h001, 12'h002, 12'h002,
    12'h008, 12'h010, 12'h020, 12'h040, 12'h080};
  localparam int unsigned SLEW_RATE_HZ [16] = '{258065, 200000, 153845,
    131145, 115940, 69565, 37560, 25805, 20150, 16030, 10295, 8280, 6900,
    5530, 4240, 3300};
endpackage : dfc_pkg
`default_nettype wire

// ### dfc_frame_cal_slew.sv
// serial frame check, gain/offset calibration and slew ramp of the dac
`default_nettype none

module dfc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : dfc_sync

// What this block does
// - with checking active, check every 32 link clocks regardless of latch
// - checked frame holds the 24-bit command above an 8-bit check byte
// - check byte uses x^8+x^2+x+1; readback frames carry one too
// - config enable bit turns checking on and moves frames to 32 bits
// - nonzero remainder pulls the fault pin low and sets the fault flag
// - fault flag clears only on soft reset, disabling checks, or reset
// - a frame failing its check changes no register
// - latch pulse without clocks realigns bit and group counters
// - data shifts in always; frames act only on a latch rising edge
// - the magic pattern in the shifter enters hidden checking mode
// - hidden mode hides from config, locks the enable, leaves on reset
// - hidden mode raises no fault and accepts frames with bad checks
// - hidden mode chains data out in 32-bit frames
// - pattern is ignored while checking is properly enabled
// - output code equals code times (gain+2^15)/2^16 plus offset
// - gain trim is unsigned 16-bit, resets to zero, half gain
// - offset trim is signed 16-bit, one lsb per step
// - calibrated code is clamped to the 16-bit or 12-bit range
// - trim changes only take effect on the next data write
// - slew enable makes the output step toward the target
// - control bits 7..5 pick step size, bits 11..8 pick update rate
// - step codes give 1..128 lsb, or fractional steps on 12-bit
// - rate codes pick update frequencies from 258065 Hz to 3300 Hz
// - reading the data register returns the instantaneous ramp value
// - status bit 1 is set while a ramp is still moving
module dfc_frame_cal_slew #(
  parameter bit RES_12 = 1'b0,
  parameter int unsigned MCLK_HZ = dfc_pkg::MCLK_HZ
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic latch,
  output logic sdo,
  output logic alarm_out,
  output logic alarm_oe_n,
  output logic frame_check_enable,
  output logic frame_check_fault_flag,
  output logic slew_active_flag,
  output logic [15:0] dac_code
);
  function automatic logic [7:0] crc_rem(input logic [31:0] f);
    logic [7:0] r;
    r = dfc_pkg::CRC_NONE;
    for (int i = 31; i >= 0; i--) begin
      r = {r[6:0], f[i]} ^ (r[7] ? dfc_pkg::CRC_POLY : dfc_pkg::CRC_NONE);
    end
    return r;
  endfunction : crc_rem

  function automatic logic [15:0] rate_cycles(input logic [3:0] s);
    int unsigned c;
    c = MCLK_HZ / dfc_pkg::SLEW_RATE_HZ[s];
    if (c < 1) begin
      c = 1;
    end
    return c[15:0];
  endfunction : rate_cycles

  logic [1:0] rst_ff;
  logic rst_s_n;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_ff <= 2'h0;
    end else begin
      rst_ff <= {rst_ff[0], 1'b1};
    end
  end
  assign rst_s_n = rst_ff[1];

  logic lrst_n;
  logic check_on_l;
  logic [31:0] sr;
  logic [4:0] bit_cnt;
  logic [7:0] rem;
  logic grp_tgl;
  logic grp_bad;
  logic pat_tgl;
  logic pat_seen;
  logic rb_seen;
  logic [31:0] rb_word;
  logic rb_tgl;
  logic check_on_m;

  dfc_sync #(.W(1)) u_lrst (.clk(sclk), .rst_n(rst_s_n), .d(1'b1),
    .q(lrst_n));
  dfc_sync #(.W(1)) u_chk_l (.clk(sclk), .rst_n(rst_s_n), .d(check_on_m),
    .q(check_on_l));

  // latch high realigns the counters even if no clock arrives
  wire cnt_clr_n = lrst_n & ~latch;
  wire grp_end = bit_cnt == dfc_pkg::GROUP_LAST_BIT;
  wire [7:0] next_rem = {rem[6:0], din} ^
    (rem[7] ? dfc_pkg::CRC_POLY : dfc_pkg::CRC_NONE);
  // readback word is written after the latch edge and stays put for the
  // whole following frame, so sampling it on the first edge is safe
  wire rb_load = (bit_cnt == 5'h00) && (rb_tgl != rb_seen);
  wire [31:0] sr_base = rb_load ? rb_word : sr;
  wire [31:0] next_sr = {sr_base[30:0], din};
  wire pat_hit = (next_sr[23:16] == dfc_pkg::PAT_HI) &&
    (next_sr[9:8] == dfc_pkg::PAT_MID) &&
    (next_sr[7:0] == dfc_pkg::PAT_LO);
  // chained output taps bit 31 in long frames, bit 23 otherwise
  assign sdo = check_on_l ? sr_base[31] : sr_base[23];

  always_ff @(posedge sclk or negedge cnt_clr_n) begin
    if (!cnt_clr_n) begin
      bit_cnt <= 5'h00;
      rem <= dfc_pkg::CRC_NONE;
    end else begin
      bit_cnt <= bit_cnt + 5'h01;
      rem <= grp_end ? dfc_pkg::CRC_NONE : next_rem;
    end
  end

  always_ff @(posedge sclk or negedge lrst_n) begin
    if (!lrst_n) begin
      sr <= 32'h0000_0000;
      grp_tgl <= 1'b0;
      grp_bad <= 1'b0;
      pat_tgl <= 1'b0;
      pat_seen <= 1'b0;
      rb_seen <= 1'b0;
    end else begin
      sr <= next_sr;
      if (grp_end && check_on_l) begin
        grp_tgl <= ~grp_tgl;
        grp_bad <= next_rem != dfc_pkg::CRC_NONE;
      end
      pat_seen <= pat_hit;
      if (pat_hit && !pat_seen) begin
        pat_tgl <= ~pat_tgl;
      end
      if (rb_load) begin
        rb_seen <= rb_tgl;
      end
    end
  end

  group_check_a: assert property (@(posedge sclk) disable iff (!cnt_clr_n)
    grp_end && check_on_l |=> grp_tgl != $past(grp_tgl))
    else $error("group of 32 clocks not checked");

  logic latch_s;
  logic grp_s;
  logic bad_s;
  logic pat_s;
  logic latch_d;
  logic grp_d;
  logic grp_d2;
  logic pat_d;
  logic [15:0] data_reg;
  logic [15:0] ctrl;
  logic [15:0] gain;
  logic [15:0] zero;
  logic cfg_en;
  logic hidden;
  logic fault;
  logic [15:0] target;
  logic [19:0] pos;
  logic [15:0] div_cnt;

  dfc_sync #(.W(4)) u_sync_m (.clk(mclk), .rst_n(rst_s_n),
    .d({latch, grp_tgl, grp_bad, pat_tgl}),
    .q({latch_s, grp_s, bad_s, pat_s}));

  wire latch_rise = latch_s & ~latch_d;
  // event one stage late so the result bit has settled past sync skew
  wire grp_evt = grp_d ^ grp_d2;
  wire pat_evt = pat_s ^ pat_d;
  wire long_m = cfg_en | hidden;
  assign check_on_m = long_m;
  // the link clock is stopped around the latch edge, so sr is quiet here
  wire [23:0] cmd = long_m ? sr[31:8] : sr[23:0];
  wire crc_ok = crc_rem(sr) == dfc_pkg::CRC_NONE;
  wire reject = cfg_en & ~hidden & ~crc_ok;
  wire accept = latch_rise & ~reject;
  wire [7:0] addr = cmd[23:16];
  wire [15:0] val = cmd[15:0];
  wire wr_data = accept && addr == dfc_pkg::ADDR_DATA;
  wire wr_ctrl = accept && addr == dfc_pkg::ADDR_CTRL;
  wire wr_cfg = accept && addr == dfc_pkg::ADDR_CFG;
  wire wr_gain = accept && addr == dfc_pkg::ADDR_GAIN;
  wire wr_zero = accept && addr == dfc_pkg::ADDR_ZERO;
  wire wr_read = accept && addr == dfc_pkg::ADDR_READ;
  wire soft_rst = accept && addr == dfc_pkg::ADDR_RESET &&
    val[dfc_pkg::RESET_BIT];

  // fault: a fresh failure wins over a clear in the same cycle
  wire fault_set = grp_evt & bad_s & cfg_en & ~hidden;
  wire fault_clr = soft_rst |
    (wr_cfg & ~hidden & ~val[dfc_pkg::CFG_CHECK_EN]);
  wire next_fault = fault_set | (fault & ~fault_clr);
  // properly enabled checking makes the pattern harmless
  wire hidden_set = pat_evt & ~cfg_en;

  // calibration, evaluated only when new data arrives
  wire [16:0] gain_term = {1'b0, gain} + dfc_pkg::GAIN_BIAS;
  wire [32:0] prod = {17'h0_0000, val} * {16'h0000, gain_term};
  wire [16:0] scaled = prod[32:16];
  wire signed [18:0] cal_sum = $signed({2'b00, scaled}) +
    $signed({{3{zero[15]}}, zero});
  wire [15:0] code_max = RES_12 ? dfc_pkg::CODE_MAX_12 :
    dfc_pkg::CODE_MAX_16;
  wire [15:0] cal_code = cal_sum[18] ? 16'h0000 :
    (cal_sum[17:0] > {2'b00, code_max}) ? code_max :
    cal_sum[15:0];

  // slew ramp
  wire slew_en = ctrl[dfc_pkg::CTRL_SLEW_EN];
  wire [2:0] step_sel = ctrl[dfc_pkg::CTRL_STEP_LSB +: 3];
  wire [3:0] rate_sel = ctrl[dfc_pkg::CTRL_RATE_LSB +: 4];
  wire [11:0] step = RES_12 ? dfc_pkg::STEP12[step_sel] :
    dfc_pkg::STEP16[step_sel];
  wire tick = div_cnt == 16'h0000;
  wire [15:0] next_div = tick ? rate_cycles(rate_sel) - 16'h0001 :
    div_cnt - 16'h0001;
  wire [19:0] tgt_f = {target, 4'h0};
  wire ramp_up = pos < tgt_f;
  wire [19:0] gap = ramp_up ? tgt_f - pos : pos - tgt_f;
  wire [19:0] move = (gap < {8'h00, step}) ? gap : {8'h00, step};
  wire [19:0] next_pos = !slew_en ? tgt_f :
    !tick ? pos :
    ramp_up ? pos + move : pos - move;
  assign dac_code = pos[19:4];
  assign slew_active_flag = pos != tgt_f;

  // readback, with check byte appended in long frames
  logic [15:0] rd_val;
  wire [15:0] status_word = {13'h0000, fault, slew_active_flag, 1'b0};
  always_comb begin
    case (val[7:0])
      dfc_pkg::ADDR_STATUS: rd_val = status_word;
      dfc_pkg::ADDR_DATA: rd_val = dac_code;
      dfc_pkg::ADDR_CTRL: rd_val = ctrl;
      dfc_pkg::ADDR_CFG: rd_val = {15'h0000, cfg_en};
      dfc_pkg::ADDR_GAIN: rd_val = gain;
      dfc_pkg::ADDR_ZERO: rd_val = zero;
      default: rd_val = 16'h0000;
    endcase
  end
  wire [31:0] rb_long = {8'h00, rd_val, 8'h00};
  wire [31:0] next_rb = long_m ?
    {rb_long[31:8], crc_rem(rb_long)} : {16'h0000, rd_val};

  always_ff @(posedge mclk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      latch_d <= 1'b0;
      grp_d <= 1'b0;
      grp_d2 <= 1'b0;
      pat_d <= 1'b0;
    end else begin
      latch_d <= latch_s;
      grp_d <= grp_s;
      grp_d2 <= grp_d;
      pat_d <= pat_s;
    end
  end

  always_ff @(posedge mclk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      hidden <= 1'b0;
      cfg_en <= 1'b0;
      fault <= 1'b0;
    end else begin
      fault <= next_fault;
      if (soft_rst) begin
        hidden <= 1'b0;
        cfg_en <= 1'b0;
      end else begin
        hidden <= hidden | hidden_set;
        if (wr_cfg && !hidden) begin
          cfg_en <= val[dfc_pkg::CFG_CHECK_EN];
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      data_reg <= 16'h0000;
      ctrl <= dfc_pkg::CTRL_RESET;
      gain <= dfc_pkg::GAIN_RESET;
      zero <= dfc_pkg::ZERO_RESET;
      target <= 16'h0000;
    end else if (soft_rst) begin
      data_reg <= 16'h0000;
      ctrl <= dfc_pkg::CTRL_RESET;
      gain <= dfc_pkg::GAIN_RESET;
      zero <= dfc_pkg::ZERO_RESET;
      target <= 16'h0000;
    end else begin
      if (wr_data) begin
        data_reg <= val;
        target <= cal_code;
      end
      if (wr_ctrl) begin
        ctrl <= val;
      end
      if (wr_gain) begin
        gain <= val;
      end
      if (wr_zero) begin
        zero <= val;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      pos <= 20'h0_0000;
      div_cnt <= 16'h0000;
      rb_word <= 32'h0000_0000;
      rb_tgl <= 1'b0;
    end else begin
      pos <= soft_rst ? 20'h0_0000 : next_pos;
      div_cnt <= next_div;
      if (wr_read) begin
        rb_word <= next_rb;
        rb_tgl <= ~rb_tgl;
      end
    end
  end

  assign frame_check_enable = cfg_en;
  assign frame_check_fault_flag = fault;
  // open drain: low enable means the pin is pulled low
  assign alarm_out = 1'b0;
  assign alarm_oe_n = ~fault;

  sequence bad_frame_s;
    latch_rise && cfg_en && !hidden && !crc_ok;
  endsequence

  bad_discard_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
    bad_frame_s |=> $stable(data_reg) && $stable(ctrl) && $stable(gain)
    && $stable(zero))
    else $error("failed frame changed a register");

  frame_split_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
    accept && long_m && sr[31:24] == dfc_pkg::ADDR_DATA
    |=> data_reg == $past(sr[23:8]))
    else $error("long frame command not taken from bits 31..8");

  fault_pin_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
    fault_set |=> frame_check_fault_flag && !alarm_oe_n)
    else $error("bad group did not raise the fault");

  fault_hold_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
    fault && !fault_clr |=> fault)
    else $error("fault flag dropped without a clearing cause");

  hidden_lock_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
    hidden && !soft_rst |=> hidden && $stable(cfg_en))
    else $error("hidden mode left or enable changed");

  hidden_quiet_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
    hidden && !fault |=> !fault)
    else $error("fault raised in hidden mode");

  readback_crc_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
    wr_read && long_m |=> crc_rem(rb_word) == dfc_pkg::CRC_NONE)
    else $error("readback frame check byte wrong");

  trim_defer_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
    (wr_gain || wr_zero) |=> $stable(target))
    else $error("trim write moved the output target");

  slew_off_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
    !slew_en && !accept ##1 !accept |-> !slew_active_flag)
    else $error("output not applied at once without slew");

  no_overshoot_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
    slew_en && ramp_up && !accept && !soft_rst |=> pos <= tgt_f)
    else $error("ramp overshot its target");

  clamp_range_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
    wr_data |=> target <= code_max)
    else $error("calibrated code out of range");
endmodule : dfc_frame_cal_slew
`default_nettype wire

// ### dfc_host_model.sv
// host processor model driving the serial link of the converter front end
`default_nettype none
module dfc_host_model (
  output logic sclk,
  output logic din,
  output logic latch,
  input wire logic sdo
);
  timeunit 1ns;
  timeprecision 100ps;
  // chained output word, sampled just before each rising link edge
  logic [31:0] rx;

  initial begin
    rx = 32'h0000_0000;
    sclk = 1'b0;
    din = 1'b1;
    latch = 1'b0;
  end

  // check byte over the command, msb first, zero start value
  function automatic logic [7:0] crc8(input logic [23:0] cmd);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ cmd[i]) ? dfc_pkg::CRC_POLY : 8'h00);
    end
    return c;
  endfunction : crc8

  // long frames carry the check byte low; bad flips one check bit
  function automatic logic [31:0] frame(input logic [7:0] a,
      input logic [15:0] d, input bit long, input bit bad);
    return long ? {a, d, crc8({a, d}) ^ {7'h00, bad}} : {8'h00, a, d};
  endfunction : frame

  // link clock runs only inside a frame, 6 ns period, odd phase offset
  // single device on the chain, so clock count follows its own mode
  task automatic send(input logic [31:0] w, input int n,
      input bit strobe);
    #1.3;
    for (int i = n - 1; i >= 0; i--) begin
      din = w[i];
      rx = {rx[30:0], sdo};
      #3 sclk = 1'b1;
      #3 sclk = 1'b0;
    end
    // released data line shows the inverse of the last bit
    din = ~din;
    if (strobe) begin
      // n of zero gives a bare latch pulse that realigns the counters
      #20 latch = 1'b1;
      #300 latch = 1'b0;
    end
  endtask : send
endmodule : dfc_host_model
`default_nettype wire

// ### tb_top.sv
// self-checking bench for the frame check, calibration and slew block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  wire sclk, din, latch, sdo, alarm_out, alarm_oe_n;
  wire frame_check_enable, frame_check_fault_flag, slew_active_flag;
  wire [15:0] dac_code;
  int errors = 0;
  int comparisons = 0;

  initial forever #25 mclk = ~mclk;

  dfc_host_model host_inst (.sclk(sclk), .din(din), .latch(latch),
    .sdo(sdo));

  // lowered system rate keeps slew divider counts short
  dfc_frame_cal_slew #(.RES_12(1'b0), .MCLK_HZ(2000000))
      dfc_frame_cal_slew_inst (.mclk(mclk), .rst_n(rst_n), .sclk(sclk),
    .din(din), .latch(latch), .sdo(sdo), .alarm_out(alarm_out),
    .alarm_oe_n(alarm_oe_n), .frame_check_enable(frame_check_enable),
    .frame_check_fault_flag(frame_check_fault_flag),
    .slew_active_flag(slew_active_flag), .dac_code(dac_code));

  task automatic test_done;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    comparisons++;
    if (seen !== want) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [15:0] d,
      input bit long, input bit bad = 1'b0);
    host_inst.send(host_inst.frame(a, d, long, bad), long ? 32 : 24, 1'b1);
    repeat (8) @(posedge mclk);
  endtask : wr

  // idle 0 waits for the code to leave v, idle 1 for the ramp to end
  task automatic wait_for(input bit idle, input logic [15:0] v);
    int n;
    n = 0;
    while (n < 2000 && (idle ? slew_active_flag !== 1'b0 : dac_code === v))
    begin
      @(posedge mclk);
      n++;
    end
    if (n == 2000) begin
      errors++;
      $display("mismatch at %0t: wait ran out", $time);
      test_done();
    end
  endtask : wait_for

  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    host_inst.send(32'h0, 2, 1'b0);
    host_inst.send(32'h0, 0, 1'b1);
    repeat (8) @(posedge mclk);
    check(dac_code, 16'h0000);
    check(16'(alarm_oe_n), 16'h0001);
    check(16'(alarm_out), 16'h0000);
    check(16'(frame_check_enable), 16'h0000);
    $display("test reset done");

    wr(dfc_pkg::ADDR_DATA, 16'h8000, 1'b0);
    check(dac_code, 16'h4000);
    wr(dfc_pkg::ADDR_GAIN, 16'h8000, 1'b0);
    check(dac_code, 16'h4000);
    wr(dfc_pkg::ADDR_DATA, 16'h1234, 1'b0);
    check(dac_code, 16'h1234);
    wr(dfc_pkg::ADDR_ZERO, 16'hfff0, 1'b0);
    wr(dfc_pkg::ADDR_DATA, 16'h0008, 1'b0);
    check(dac_code, 16'h0000);
    wr(dfc_pkg::ADDR_ZERO, 16'h0020, 1'b0);
    wr(dfc_pkg::ADDR_DATA, 16'hfff0, 1'b0);
    check(dac_code, 16'hffff);
    wr(dfc_pkg::ADDR_ZERO, 16'h0000, 1'b0);
    wr(dfc_pkg::ADDR_DATA, 16'h0000, 1'b0);
    check(dac_code, 16'h0000);
    $display("test calibration done");

    // slowest rate, 128 lsb steps, target not a step multiple
    wr(dfc_pkg::ADDR_CTRL, 16'h0ff0, 1'b0);
    wr(dfc_pkg::ADDR_DATA, 16'h0150, 1'b0);
    check(dac_code, 16'h0000);
    check(16'(slew_active_flag), 16'h0001);
    wait_for(1'b0, 16'h0000);
    check(dac_code, 16'h0080);
    wait_for(1'b0, 16'h0080);
    check(dac_code, 16'h0100);
    wait_for(1'b1, 16'h0000);
    check(dac_code, 16'h0150);
    wr(dfc_pkg::ADDR_CTRL, 16'h0000, 1'b0);
    wr(dfc_pkg::ADDR_DATA, 16'h0020, 1'b0);
    check(dac_code, 16'h0020);
    wr(dfc_pkg::ADDR_READ, 16'h0001, 1'b0);
    wr(dfc_pkg::ADDR_STATUS, 16'h0000, 1'b0);
    check(host_inst.rx[15:0], 16'h0020);
    check(16'(host_inst.rx[23:16]), 16'h0000);
    $display("test slew done");

    wr(dfc_pkg::ADDR_CFG, 16'h0001, 1'b0);
    check(16'(frame_check_enable), 16'h0001);
    wr(dfc_pkg::ADDR_DATA, 16'h0042, 1'b1);
    check(dac_code, 16'h0042);
    // stray clocks, then a bare latch pulse realigns the groups
    host_inst.send(32'h5, 5, 1'b0);
    host_inst.send(32'h0, 0, 1'b1);
    wr(dfc_pkg::ADDR_DATA, 16'h0043, 1'b1);
    check(dac_code, 16'h0043);
    check(16'(frame_check_fault_flag), 16'h0000);
    wr(dfc_pkg::ADDR_DATA, 16'h0077, 1'b1, 1'b1);
    check(dac_code, 16'h0043);
    check(16'(frame_check_fault_flag), 16'h0001);
    check(16'(alarm_oe_n), 16'h0000);
    wr(dfc_pkg::ADDR_DATA, 16'h0044, 1'b1);
    check(16'(frame_check_fault_flag), 16'h0001);
    // pattern while properly enabled must not lock the enable
    host_inst.send(32'h0057032b, 24, 1'b0);
    host_inst.send(32'h0, 0, 1'b1);
    wr(dfc_pkg::ADDR_CFG, 16'h0000, 1'b1);
    check(16'(frame_check_enable), 16'h0000);
    check(16'(frame_check_fault_flag), 16'h0000);
    check(16'(alarm_oe_n), 16'h0001);
    $display("test frame check done");

    // pattern shifted in with no latch edge at all
    host_inst.send(32'h0057032b, 24, 1'b0);
    repeat (8) @(posedge mclk);
    check(16'(frame_check_enable), 16'h0000);
    wr(dfc_pkg::ADDR_DATA, 16'h0099, 1'b1, 1'b1);
    check(dac_code, 16'h0099);
    check(16'(frame_check_fault_flag), 16'h0000);
    check(16'(alarm_oe_n), 16'h0001);
    wr(dfc_pkg::ADDR_READ, 16'h0001, 1'b1);
    wr(dfc_pkg::ADDR_STATUS, 16'h0000, 1'b1);
    check(host_inst.rx[23:8], 16'h0099);
    check(16'(host_inst.rx[7:0]), 16'(host_inst.crc8(24'h000099)));
    wr(dfc_pkg::ADDR_CFG, 16'h0001, 1'b1);
    check(16'(frame_check_enable), 16'h0000);
    wr(dfc_pkg::ADDR_RESET, 16'h0001, 1'b1);
    check(dac_code, 16'h0000);
    wr(dfc_pkg::ADDR_DATA, 16'h8000, 1'b0);
    check(dac_code, 16'h4000);
    $display("test hidden mode done");
    test_done();
  end
endmodule : tb_top
`default_nettype wire
